// *** core/lsp_params.svh ***
// Constants of the LIN capable serial port: offsets, field positions, counts.
// Assumes inclusion by bare name from the serial port core, the only file that includes it.
`ifndef LSP_PARAMS_SVH
`define LSP_PARAMS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LSP_A_BDH 4'h0
`define LSP_A_BDL 4'h1
`define LSP_A_STAT 4'h2
`define LSP_A_CTRL2 4'h3
`define LSP_A_CTRL3 4'h4
`define LSP_A_STAT2 4'h5
`define LSP_A_DATA 4'h6
`define LSP_A_CLR 4'h7
`define LSP_A_CTRL1 4'h8
// ----------------------------------------------------------------------
// Field positions (status and clear register share them)
// ----------------------------------------------------------------------
`define LSP_F_TE 7
`define LSP_F_TF 6
`define LSP_F_RI 5
`define LSP_F_ID 4
`define LSP_F_RO 3
`define LSP_F_NF 2
`define LSP_F_FE 1
`define LSP_F_PE 0
`define LSP_F_BKF 7
`define LSP_F_EDF 6
`define LSP_RST_DATA 8'hFF
// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define LSP_RT_S3 4'h3
`define LSP_RT_S5 4'h5
`define LSP_RT_S7 4'h7
`define LSP_RT_S8 4'h8
`define LSP_RT_S9 4'h9
`define LSP_RT_S10 4'hA
`define LSP_RT_LAST 4'hF
`define LSP_FRAME_BASE 4'hA
`define LSP_BRK_LONG 4'hD
`define LSP_BRKDET_BASE 4'hB
`define LSP_AB_EDGES 3'h5
`define LSP_AB_SHIFT 7
`define LSP_AB_MAX 20'hF_FFFF
`define LSP_MATCH_LO 3'h3
`define LSP_MATCH_HI 3'h7
`define LSP_MATCH_DEN 3'h5
`endif

// *** core/lsp_pkg.sv ***
// Types shared by the serial port files.
// Assumes nothing beyond a SystemVerilog compiler.
package lsp_pkg;
  typedef enum logic [3:0] {
    LSP_RX_IDLE = 4'b0001,
    LSP_RX_START = 4'b0010,
    LSP_RX_DATA = 4'b0100,
    LSP_RX_STOP = 4'b1000
  } lsp_rx_e;
  typedef enum logic [1:0] {
    LSP_TX_IDLE = 2'b01,
    LSP_TX_BUSY = 2'b10
  } lsp_tx_e;
  // Frame length grows by one bit each for nine-bit mode and two stops
  function automatic logic [3:0] lsp_frame_bits(input logic [3:0] base, input logic dm,
                                                input logic sm);
    lsp_frame_bits = base + {3'h0, dm} + {3'h0, sm};
  endfunction
endpackage

// *** core/lsp_baud_gen.sv ***
// Baud tick generator: one pulse every div_in clocks, the 16x sample rate.
// Assumes div_in is stable except around restart_in.
`timescale 1ns/1ns
module lsp_baud_gen (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [12:0] div_in,
  input wire logic restart_in,
  output logic tick_out
);
  import lsp_pkg::*;
  typedef struct packed {
    logic [12:0] cnt;
  } lsp_bg_s;
  lsp_bg_s s;
  lsp_bg_s next_s;
  always_comb begin
    next_s = s;
    tick_out = 1'b0;
    // Zero divisor holds the count at zero with no tick; a restart realigns on the new value
    if (restart_in || div_in == 13'h0) begin
      next_s.cnt = 13'h0;
    end else if (s.cnt == div_in - 13'h1) begin
      next_s.cnt = 13'h0;
      tick_out = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 13'h1;
    end
  end
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// *** core/lsp_rx_front.sv ***
// Receive front end: two-stage synchroniser and 16x falling edge search.
// Assumes pin_in may be asynchronous; tick_in is a one-cycle 16x pulse.
`timescale 1ns/1ns
module lsp_rx_front (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic pin_in,
  input wire logic tick_in,
  output logic level_out,
  output logic fall_out
);
  import lsp_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic [2:0] hist;
  } lsp_fe_s;
  lsp_fe_s s;
  lsp_fe_s next_s;
  always_comb begin
    next_s = s;
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
    if (tick_in) begin
      next_s.hist = {s.hist[1:0], s.s2};
    end
    level_out = s.s2;
    // A low sample after three high ones marks an edge
    fall_out = tick_in && !s.s2 && (&s.hist);
  end
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= 5'b11111;
    end else begin
      s <= next_s;
    end
  end
endmodule

// *** core/lsp_serial_port.sv ***
// Serial port core: registers, transmitter, receiver, rate matching.
// Assumes a single-clock register master and asynchronous serial pins.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`include "lsp_params.svh"
//
// Operation
// - Baud tick every 13-bit divisor clocks; zero divisor gives no tick.
// - Writing either divisor register restarts the baud counter.
// - Rate match times start fall to eighth bit fall, loads divisor.
// - Sync character is received normally; deviation above 40% fails.
// - Transmit line idles high; inversion flips the whole output.
// - Enable 0-1 queues preamble, break 1-0 queues break, data queues data.
// - Preamble is high for 10, 11 or 12 bit times.
// - Disabling finishes the current character and drops the queue.
// - Data frame: start, 8 or 9 data bits, one or two stops.
// - Buffer-vacant flag sets on shifter load and on enable rising.
// - Break is low 10 or 13 bits plus options; requeued if still set.
// - Nothing pending after last stop: complete flag, idle, line high.
// - Received character goes to buffer or sets overrun; input invertible.
// - Break detect counts low bit times; rising edge clears the count.
// - Idle detect arms after first full, counts high bit times.
// - Break flag independent of data; disabled means breaks are ignored.
// - Sample at 16x; edge is a low after three highs.
// - Start accepted if two of slots 3, 5, 7 are low.
// - Bit value is majority of slots 8-10; disagreements set noise.
// - Sleep blocks receive flags; idle or address mark wakes.
// - Loop and single-wire modes reroute the receive input.
// - Low receive level wakes the system when the port, receiver and edge enables are set.
// - Writing 1 to the clear register clears the matching flag.
module lsp_serial_port (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rd_data_out,
  input wire logic rxd_in,
  input wire logic txd_in,
  output logic txd_out,
  output logic txd_oe_out,
  output logic wake_out
);
  import lsp_pkg::*;
  typedef struct packed {
    logic [4:0] bdh;
    logic [7:0] bdl;
    logic ten, ren, rwu, brk, ninth_tx_bit, dir, tinv, rinv, rwis, isel, wsel;
    logic bk_ie, edge_ie, bk_size, bk_en;
    logic cyc, stop2, sgl, dm, pen, psel, rm, en;
    logic te, tf, ri, idl, ro, nf, fe, pe, bkf, edf;
    lsp_tx_e txs;
    logic [3:0] tsub;
    logic [3:0] tleft;
    logic [12:0] tsh;
    logic pend_pre, pend_brk, pend_dat;
    logic [7:0] tbuf;
    logic txl, txoe;
    lsp_rx_e rxs;
    logic [3:0] rt;
    logic [1:0] zc;
    logic noise;
    logic [2:0] vot;
    logic [3:0] ridx;
    logic [8:0] rsh;
    logic [7:0] rbuf;
    logic ninth_rx_bit, seen_full;
    logic [7:0] lowcnt;
    logic bk_hold;
    logic [7:0] hicnt;
    logic id_hold;
    logic ab_run;
    logic [2:0] ab_edges;
    logic [19:0] ab_cnt;
    logic lvl_d;
    logic [7:0] rdat;
    logic wake;
  } lsp_core_s;
  lsp_core_s s;
  lsp_core_s next_s;
  logic tick, level, fall, raw_rx, bd_restart, ab_load;
  logic [12:0] ab_div;
  // ----------------------------------------------------------------------
  // Baud generation and receive path
  // ----------------------------------------------------------------------
  lsp_baud_gen u_baud (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .div_in({s.bdh, s.bdl}),
    .restart_in(bd_restart),
    .tick_out(tick)
  );
  // Loop mode takes the internal line; single wire listens on the tx pin, or on the internal line when dir is set
  always_comb begin
    if (s.cyc && !s.sgl) begin
      raw_rx = s.txl ^ s.tinv;
    end else if (s.cyc && s.sgl) begin
      raw_rx = (s.dir ? s.txl : txd_in) ^ s.rinv;
    end else begin
      raw_rx = rxd_in ^ s.rinv;
    end
  end
  lsp_rx_front u_front (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(raw_rx),
    .tick_in(tick),
    .level_out(level),
    .fall_out(fall)
  );
  assign bd_restart = (wr_in && (addr_in == `LSP_A_BDH || addr_in == `LSP_A_BDL))
                      || ab_load;
  assign ab_div = s.ab_cnt[19:`LSP_AB_SHIFT];
  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [3:0] rt_n;
    logic [15:0] old5;
    logic [15:0] new5;
    logic maj, msb, wr_ok, fin;
    logic [7:0] chr;
    logic [12:0] fr;
    next_s = s;
    rt_n = s.rt + 4'h1;
    old5 = 16'h0;
    new5 = 16'h0;
    maj = 1'b0;
    msb = 1'b0;
    wr_ok = 1'b0;
    fin = 1'b0;
    chr = 8'h0;
    fr = 13'h1FFF;
    ab_load = 1'b0;
    // Register writes; clears go first so that same-cycle events win
    if (wr_in) begin
      case (addr_in)
        `LSP_A_BDH: next_s.bdh = wr_data_in[4:0];
        `LSP_A_BDL: next_s.bdl = wr_data_in;
        `LSP_A_CTRL2: begin
          next_s.ten = wr_data_in[3];
          next_s.ren = wr_data_in[2];
          next_s.rwu = wr_data_in[1];
          next_s.brk = wr_data_in[0];
          if (!s.ten && wr_data_in[3]) begin
            next_s.pend_pre = 1'b1;
            next_s.te = 1'b1;
          end
          if (s.ten && !wr_data_in[3]) begin
            next_s.pend_pre = 1'b0;
            next_s.pend_brk = 1'b0;
            next_s.pend_dat = 1'b0;
          end
          if (s.brk && !wr_data_in[0]) begin
            next_s.pend_brk = 1'b1;
          end
        end
        `LSP_A_CTRL3: begin
          next_s.ninth_tx_bit = wr_data_in[6];
          next_s.dir = wr_data_in[5];
          next_s.tinv = wr_data_in[4];
          next_s.rinv = wr_data_in[3];
          next_s.rwis = wr_data_in[2];
          next_s.isel = wr_data_in[1];
          next_s.wsel = wr_data_in[0];
        end
        `LSP_A_STAT2: begin
          next_s.bkf = s.bkf && !wr_data_in[`LSP_F_BKF];
          next_s.edf = s.edf && !wr_data_in[`LSP_F_EDF];
          next_s.bk_ie = wr_data_in[3];
          next_s.edge_ie = wr_data_in[2];
          next_s.bk_size = wr_data_in[1];
          next_s.bk_en = wr_data_in[0];
        end
        `LSP_A_DATA: begin
          next_s.tbuf = wr_data_in;
          next_s.pend_dat = 1'b1;
        end
        `LSP_A_CLR: begin
          next_s.te = s.te && !wr_data_in[`LSP_F_TE];
          next_s.tf = s.tf && !wr_data_in[`LSP_F_TF];
          next_s.ri = s.ri && !wr_data_in[`LSP_F_RI];
          next_s.idl = s.idl && !wr_data_in[`LSP_F_ID];
          next_s.ro = s.ro && !wr_data_in[`LSP_F_RO];
          next_s.nf = s.nf && !wr_data_in[`LSP_F_NF];
          next_s.fe = s.fe && !wr_data_in[`LSP_F_FE];
          next_s.pe = s.pe && !wr_data_in[`LSP_F_PE];
        end
        `LSP_A_CTRL1: begin
          {next_s.cyc, next_s.stop2, next_s.sgl, next_s.dm} = wr_data_in[7:4];
          {next_s.pen, next_s.psel, next_s.rm, next_s.en} = wr_data_in[3:0];
        end
        default: begin
        end
      endcase
    end
    // ----------------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------------
    fin = s.txs == LSP_TX_BUSY && tick && s.tsub == `LSP_RT_LAST && s.tleft == 4'h1;
    if (s.txs == LSP_TX_BUSY && tick && !fin) begin
      next_s.tsub = s.tsub + 4'h1;
      if (s.tsub == `LSP_RT_LAST) begin
        next_s.tsh = {s.tsh[12], s.tsh[12:1]};
        next_s.tleft = s.tleft - 4'h1;
      end
    end
    if (s.ten && s.en && (s.txs == LSP_TX_IDLE || fin)) begin
      next_s.txs = LSP_TX_BUSY;
      next_s.tsub = 4'h0;
      if (s.pend_pre) begin
        next_s.pend_pre = 1'b0;
        next_s.tsh = 13'h1FFF;
        next_s.tleft = lsp_frame_bits(`LSP_FRAME_BASE, s.dm, s.stop2);
      end else if (s.pend_brk) begin
        next_s.pend_brk = s.brk;
        next_s.tsh = 13'h0;
        next_s.tleft = lsp_frame_bits(s.bk_size ? `LSP_BRK_LONG : `LSP_FRAME_BASE,
                                      s.dm, s.stop2);
      end else if (s.pend_dat) begin
        fr[8:1] = s.tbuf;
        fr[0] = 1'b0;
        if (s.dm) begin
          fr[9] = s.ninth_tx_bit;
        end
        next_s.pend_dat = 1'b0;
        next_s.te = 1'b1;
        next_s.tsh = fr;
        next_s.tleft = lsp_frame_bits(`LSP_FRAME_BASE, s.dm, s.stop2);
      end else if (fin) begin
        next_s.txs = LSP_TX_IDLE;
        next_s.tf = 1'b1;
      end else begin
        next_s.txs = LSP_TX_IDLE;
      end
    end else if (fin) begin
      next_s.txs = LSP_TX_IDLE;
      next_s.tf = next_s.tf || !(s.pend_pre || s.pend_brk || s.pend_dat);
    end
    next_s.txl = (next_s.txs == LSP_TX_BUSY) ? next_s.tsh[0] : 1'b1;
    next_s.txoe = !(next_s.cyc && next_s.sgl && !next_s.dir);
    // ----------------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------------
    if (!(s.ren && s.en)) begin
      next_s.rxs = LSP_RX_IDLE;
    end else if (tick) begin
      case (s.rxs)
        LSP_RX_IDLE: begin
          if (fall) begin
            next_s.rxs = LSP_RX_START;
            next_s.rt = 4'h1;
            next_s.zc = 2'h0;
            next_s.noise = 1'b0;
          end
        end
        LSP_RX_START: begin
          next_s.rt = rt_n;
          if (rt_n >= `LSP_RT_S3 && rt_n <= `LSP_RT_S10 && level) begin
            next_s.noise = 1'b1;
          end
          if ((rt_n == `LSP_RT_S3 || rt_n == `LSP_RT_S5 || rt_n == `LSP_RT_S7) && !level) begin
            next_s.zc = s.zc + 2'h1;
          end
          if (rt_n == `LSP_RT_S7 && (s.zc + {1'b0, !level}) < 2'h2) begin
            next_s.rxs = LSP_RX_IDLE;
          end
          if (rt_n == 4'h0) begin
            next_s.rxs = LSP_RX_DATA;
            next_s.ridx = 4'h0;
          end
        end
        LSP_RX_DATA, LSP_RX_STOP: begin
          next_s.rt = rt_n;
          if (rt_n >= `LSP_RT_S8 && rt_n <= `LSP_RT_S10) begin
            next_s.vot = {s.vot[1:0], level};
          end
          if (rt_n == `LSP_RT_S10) begin
            maj = (s.vot[1] & s.vot[0]) | (s.vot[1] & level) | (s.vot[0] & level);
            if (!(s.vot[1] == level && s.vot[0] == level)) begin
              next_s.noise = 1'b1;
            end
            if (s.rxs == LSP_RX_DATA) begin
              next_s.rsh = {maj, s.rsh[8:1]};
              next_s.ridx = s.ridx + 4'h1;
            end
          end
          if (s.rxs == LSP_RX_DATA && rt_n == 4'h0 && s.ridx == (s.dm ? 4'h9 : 4'h8)) begin
            next_s.rxs = LSP_RX_STOP;
          end
          if (s.rxs == LSP_RX_STOP && rt_n == `LSP_RT_S10) begin
            next_s.rxs = LSP_RX_IDLE;
            chr = s.dm ? s.rsh[7:0] : s.rsh[8:1];
            msb = s.dm ? s.rsh[8] : s.rsh[8];
            wr_ok = !s.rwu || (s.wsel && msb);
            if (s.rwu && s.wsel && msb) begin
              next_s.rwu = 1'b0;
            end
            if (wr_ok && !s.ri) begin
              next_s.rbuf = chr;
              next_s.ninth_rx_bit = s.rsh[8];
              next_s.ri = 1'b1;
              next_s.seen_full = 1'b1;
              next_s.nf = next_s.nf || next_s.noise;
              next_s.fe = next_s.fe || !maj;
            end else if (wr_ok) begin
              next_s.ro = 1'b1;
            end
          end
        end
        default: next_s.rxs = LSP_RX_IDLE;
      endcase
    end
    // Break detection runs beside data reception
    if (!s.bk_en) begin
      next_s.lowcnt = 8'h0;
      next_s.bk_hold = 1'b0;
    end else if (tick) begin
      if (level) begin
        next_s.lowcnt = 8'h0;
        next_s.bk_hold = 1'b0;
      end else if (!s.bk_hold) begin
        next_s.lowcnt = s.lowcnt + 8'h1;
        if (next_s.lowcnt == {lsp_frame_bits(`LSP_BRKDET_BASE, s.dm, s.stop2), 4'h0}) begin
          next_s.bk_hold = 1'b1;
          next_s.bkf = !s.rwu || next_s.bkf;
          next_s.ab_run = 1'b0;
        end
      end
    end
    // Idle line detection, armed once the buffer has filled
    if (tick && s.seen_full) begin
      if (!level) begin
        next_s.hicnt = 8'h0;
        next_s.id_hold = 1'b0;
      end else if (!s.id_hold && (!s.isel || s.rxs == LSP_RX_IDLE)) begin
        next_s.hicnt = s.hicnt + 8'h1;
        if (next_s.hicnt == {lsp_frame_bits(`LSP_FRAME_BASE, s.dm, s.stop2), 4'h0}) begin
          next_s.id_hold = 1'b1;
          if (!s.rwu || s.rwis) begin
            next_s.idl = 1'b1;
          end
          if (s.rwu && !s.wsel) begin
            next_s.rwu = 1'b0;
          end
        end
      end
    end
    // ----------------------------------------------------------------------
    // Rate matching on the 0x55 sync character
    // ----------------------------------------------------------------------
    next_s.lvl_d = level;
    if (!s.rm) begin
      next_s.ab_run = 1'b0;
    end else if (s.lvl_d && !level) begin
      if (!s.ab_run && s.rxs == LSP_RX_IDLE) begin
        next_s.ab_run = 1'b1;
        next_s.ab_cnt = 20'h0;
        next_s.ab_edges = 3'h1;
      end else if (s.ab_run) begin
        next_s.ab_edges = s.ab_edges + 3'h1;
        if (next_s.ab_edges == `LSP_AB_EDGES) begin
          next_s.ab_run = 1'b0;
          old5 = 16'({s.bdh, s.bdl}) * 16'(`LSP_MATCH_DEN);
          new5 = 16'(ab_div) * 16'(`LSP_MATCH_DEN);
          if (ab_div != 13'h0 && ({s.bdh, s.bdl} == 13'h0 ||
              (new5 >= 16'({s.bdh, s.bdl}) * 16'(`LSP_MATCH_LO) &&
               new5 <= 16'({s.bdh, s.bdl}) * 16'(`LSP_MATCH_HI)))) begin
            ab_load = 1'b1;
            {next_s.bdh, next_s.bdl} = ab_div;
          end
        end
      end
    end else if (s.ab_run) begin
      if (s.ab_cnt == `LSP_AB_MAX) begin
        next_s.ab_run = 1'b0; // Far too slow to be a sync character
      end else begin
        next_s.ab_cnt = s.ab_cnt + 20'h1;
      end
    end
    if (s.lvl_d && !level) begin
      next_s.edf = 1'b1;
    end
    next_s.wake = s.en && s.ren && s.edge_ie && !level;
    // ----------------------------------------------------------------------
    // Read port: data stands one cycle after the strobe
    // ----------------------------------------------------------------------
    next_s.rdat = 8'h0;
    if (rd_in) begin
      case (addr_in)
        `LSP_A_BDH: next_s.rdat = {3'h0, s.bdh};
        `LSP_A_BDL: next_s.rdat = s.bdl;
        `LSP_A_STAT: next_s.rdat = {s.te, s.tf, s.ri, s.idl, s.ro, s.nf, s.fe, s.pe};
        `LSP_A_CTRL2: next_s.rdat = {4'h0, s.ten, s.ren, s.rwu, s.brk};
        `LSP_A_CTRL3: next_s.rdat = {s.ninth_rx_bit, s.ninth_tx_bit, s.dir, s.tinv, s.rinv,
                                     s.rwis, s.isel, s.wsel};
        `LSP_A_STAT2: next_s.rdat = {s.bkf, s.edf, s.rxs != LSP_RX_IDLE, 1'b0,
                                     s.bk_ie, s.edge_ie, s.bk_size, s.bk_en};
        `LSP_A_DATA: next_s.rdat = s.rbuf;
        `LSP_A_CTRL1: next_s.rdat = {s.cyc, s.stop2, s.sgl, s.dm, s.pen, s.psel, s.rm, s.en};
        default: next_s.rdat = 8'h0;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= '0;
      s.txs <= LSP_TX_IDLE;
      s.rxs <= LSP_RX_IDLE;
      s.txl <= 1'b1;
      s.txoe <= 1'b1;
      s.lvl_d <= 1'b1;
      s.rbuf <= `LSP_RST_DATA;
      s.tbuf <= `LSP_RST_DATA;
      s.tsh <= 13'h1FFF;
    end else begin
      s <= next_s;
    end
  end
  assign rd_data_out = s.rdat;
  // Inversion is applied before a separate output flop, which registers the next line value xor the next invert bit
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      txd_out <= 1'b1;
    end else begin
      txd_out <= next_s.txl ^ next_s.tinv;
    end
  end
  assign txd_oe_out = s.txoe;
  assign wake_out = s.wake;
endmodule

// *** verif/lsp_serial_port_sva.sv ***
// Checker for the serial port: register read port, pin timing, wake level.
// Assumes binding to lsp_serial_port; it mirrors the control writes itself.
`timescale 1ns/1ns
module lsp_serial_port_chk (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rd_data_out,
  input wire logic rxd_in,
  input wire logic txd_in,
  input wire logic txd_out,
  input wire logic txd_oe_out,
  input wire logic wake_out
);
  // ----------
  // Mirrors of written registers
  // ----------
  logic [7:0] m [0:8];
  logic [16:0] gap;
  logic [2:0] wh;
  logic dirty;
  logic fresh;
  wire logic [12:0] div = {m[0][4:0], m[1]};
  wire logic en = m[8][0] && m[3][2] && m[5][2];
  // Pin outputs lag a write by up to three cycles, so checks wait that long
  wire logic quiet = !wr_in && wh == 3'h0;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      m <= '{default: 8'h00};
      gap <= 17'h1_ffff;
      wh <= 3'h0;
      dirty <= 1'b0;
      fresh <= 1'b1;
    end else begin
      if (wr_in && addr_in <= 4'h8) m[addr_in] <= wr_data_in;
      wh <= {wh[1:0], wr_in};
      dirty <= wr_in || (dirty && !$changed(txd_out));
      fresh <= fresh && !(wr_in && addr_in == 4'h3 && wr_data_in[3]);
      gap <= $changed(txd_out) ? 17'h0_0001 : gap + {16'h0000, gap != 17'h1_ffff};
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  property p_gap; $changed(txd_out) && !dirty |-> gap >= {div, 4'h0}; endproperty
  a_gap: assert property (p_gap) else $error("tx bit too short");
  property p_zero; div == 13'h0000 && quiet |=> $stable(txd_out); endproperty
  a_zero: assert property (p_zero) else $error("tx moved with zero divisor");
  property p_idle; fresh && quiet |-> txd_out == !m[4][4]; endproperty
  a_idle: assert property (p_idle) else $error("tx idle level wrong");
  property p_oe; quiet |-> txd_oe_out == !(m[8][7] && m[8][5] && !m[4][5]); endproperty
  a_oe: assert property (p_oe) else $error("tx pin enable wrong");
  property p_wake; (en && !rxd_in && quiet) [*5] |-> wake_out; endproperty
  a_wake: assert property (p_wake) else $error("wake missing");
  property p_wrise; $rose(wake_out) |-> !($past(rxd_in, 2) && $past(rxd_in, 3)); endproperty
  a_wrise: assert property (p_wrise) else $error("wake without low rx");
  property p_clr; rd_in && addr_in == 4'h7 |=> rd_data_out == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("clear register read not zero");
  property p_rdq; !rd_in |=> rd_data_out == 8'h00; endproperty
  a_rdq: assert property (p_rdq) else $error("read data outside read slot");
endmodule
bind lsp_serial_port lsp_serial_port_chk u_chk (.mclk_in, .sys_rst_in, .addr_in, .wr_data_in,
  .wr_in, .rd_in, .rd_data_out, .rxd_in, .txd_in, .txd_out, .txd_oe_out, .wake_out);

// *** verif/lsp_remote_node.sv ***
// Remote serial node: decodes frames on the tx line, sends frames on rx.
// Assumes one bit lasts BIT clocks on both sides; the lines idle high.
`timescale 1ns/1ns
module lsp_remote_node #(
  parameter int BIT = 16
) (
  input wire logic mclk_in,
  input wire logic line_in,
  output logic rxd_out,
  output logic got_out,
  output logic [7:0] byte_out
);
  // ----------
  // Frame engine
  // ----------
  initial rxd_out = 1'b1;
  initial got_out = 1'b0;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_out <= f[i];
      repeat (BIT) @(posedge mclk_in);
    end
  endtask
  // Two low samples only, too short to pass for a start bit
  task automatic glitch();
    rxd_out <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rxd_out <= 1'b1;
    repeat (BIT) @(posedge mclk_in);
  endtask
  // Samples mid-bit; a low stop (a break) is not reported
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge mclk_in);
    // High again at mid start bit is a short pulse, not a frame
    if (!line_in) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge mclk_in);
        byte_out[i] = line_in;
      end
      repeat (BIT) @(posedge mclk_in);
      got_out <= line_in;
      @(posedge mclk_in);
      got_out <= 1'b0;
    end
  end
endmodule

// *** verif/tb.sv ***
// Testbench: register port stimulus, remote node traffic, queued compares.
// Assumes divisor 1, so one bit is 16 clocks.
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdat = 8'h00;
  logic [7:0] rdat;
  logic [7:0] gb;
  logic [7:0] b;
  logic txd;
  logic oe;
  logic wake;
  logic rxd;
  logic got;
  logic [15:0] rq[$];
  logic [7:0] tq[$];
  int errors = 0;
  int checks = 0;
  int n;
  int seed = 32'h7eb6_ad12;
  // Pin pulled up while nobody drives it
  wire logic pin = oe ? txd : 1'b1;
  always #4 clk = ~clk;
  lsp_serial_port dut (.mclk_in(clk), .sys_rst_in(rst), .addr_in(addr), .wr_data_in(wdat),
    .wr_in(wr), .rd_in(rd), .rd_data_out(rdat), .rxd_in(rxd), .txd_in(pin), .txd_out(txd),
    .txd_oe_out(oe), .wake_out(wake));
  lsp_remote_node #(.BIT(16)) peer (.mclk_in(clk), .line_in(pin), .rxd_out(rxd),
    .got_out(got), .byte_out(gb));
  // ----------
  // Tasks and watchers
  // ----------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rq.push_back({m, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      chk(rdat & rq[0][15:8], rq[0][7:0]);
      rq.delete(0);
    end
    if (got) begin
      chk(gb, tq[0]);
      tq.delete(0);
    end
  end
  initial begin
    #200000;
    errors++;
    close_out;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rreg(4'hf, 8'hff, 8'h00);
    rreg(4'h6, 8'hff, 8'hff);
    rreg(4'h7, 8'hff, 8'h00);
    wreg(4'h4, 8'h10);
    repeat (4) @(posedge clk);
    chk({7'h00, txd}, 8'h00);
    wreg(4'h4, 8'h00);
    wreg(4'h1, 8'h01);
    rreg(4'h1, 8'hff, 8'h01);
    wreg(4'h8, 8'h01);
    wreg(4'h3, 8'h0c);
    rreg(4'h2, 8'h80, 8'h80);
    b = 8'($random(seed));
    tq.push_back(b);
    wreg(4'h6, b);
    n = 0;
    while (tq.size() > 0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk(8'(tq.size()), 8'h00);
    repeat (16) @(posedge clk);
    rreg(4'h2, 8'hc0, 8'hc0);
    wreg(4'h7, 8'h00);
    rreg(4'h2, 8'hc0, 8'hc0);
    wreg(4'h7, 8'h40);
    rreg(4'h2, 8'hc0, 8'h80);
    peer.glitch();
    b = 8'($random(seed));
    peer.send(b);
    peer.send(~b);
    repeat (32) @(posedge clk);
    rreg(4'h2, 8'h2e, 8'h28);
    rreg(4'h6, 8'hff, b);
    wreg(4'h3, 8'h0d);
    wreg(4'h3, 8'h0c);
    n = 0;
    while (txd && n < 200) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (!txd && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(n[7:0], 8'ha0);
    wreg(4'h5, 8'h04);
    peer.send(8'h00);
    wreg(4'h8, 8'ha1);
    repeat (4) @(posedge clk);
    chk({7'h00, oe}, 8'h00);
    wreg(4'h8, 8'h01);
    wreg(4'h1, 8'h00);
    repeat (40) @(posedge clk);
    close_out;
  end
endmodule
